// [core/ring_command_buffer_regs.v]
// Ring command buffer registers and ring fetch sequencing.
// Assumes the register port, instruction parser, memory and engines all run
// on the one core clock; memory returns one dword per fetch request.
`include "ring_command_buffer_consts.vh"

// Operation
// - Writing the start address clears head offset and wrap count.
// - Start address keeps bits 28:12; bits 31:29 and the low twelve bits read zero.
// - Ring fetches always go through the global translation table.
// - Length field is pages minus one, 0 is 4 KB, 1FFh is 2 MB.
// - Control bit 11 reads set while the ring waits for an event.
// - Writing 1 clears the wait flag and resumes fetching; 0 does nothing.
// - Report field 0 off, 1 every 64 KB, 3 every 128 KB, 2 reserved.
// - With per-process queue mode set, encoding 1 reports every 4 KB.
// - Each report writes the current head pointer to the status page.
// - Control bit 0 enables the ring, empty or not.
// - Head bit 0 reads set while waiting for a condition code.
// - Pending head pointer holds address bits 31:3 for the next arbitration check.
// - Software sets valid; hardware clears it on use, taking that pointer.
// - Valid clear at arbitration check means continue without a jump.
// - Reading memory read sync starts a flush and returns zero.
// - Error location bit 3 tells batch buffer from direct ring.
// - Error location bits 2:0 name ring 0.
// - Non-zero snoop sync write flushes; once flushed the shared offset reads the error location.
// - Error header loads the first dword of every executed instruction.
// - Unit done bits read-only, reset value 0FFE7FFEh.
// - Wrap count increments on each head wrap and wraps on overflow.
module ring_command_buffer_regs (
  input  wire        clock,                // Core clock
  input  wire        reset,                // Synchronous reset, active high
  input  wire        reg_write,            // Register write strobe
  input  wire        reg_read,             // Register read strobe
  input  wire [15:0] reg_address,          // Register byte offset
  input  wire [31:0] reg_write_data,       // Register write data
  output reg  [31:0] reg_read_data,        // Register read data
  output reg         reg_read_valid,       // Read data valid pulse
  input  wire        per_process_mode,     // Per-process space and queue enable
  output reg         fetch_request,        // Ring fetch request, held
  output reg  [31:0] fetch_address,        // Ring fetch graphics address
  output reg         fetch_global_table,   // Fetch uses global table
  input  wire        fetch_data_valid,     // Fetched dword valid
  input  wire [31:0] fetch_data,           // Fetched dword
  output reg         instruction_valid,    // Dword to parser valid
  output reg  [31:0] instruction_data,     // Dword to parser
  input  wire        command_header_valid, // Parser saw an instruction header
  input  wire [31:0] command_header,       // Header dword
  input  wire        command_wait_event,   // Parser executed an event wait
  input  wire        event_satisfied,      // Awaited event occurred
  input  wire        command_arb_check,    // Parser executed arbitration check
  input  wire        command_error,        // Invalid instruction error
  input  wire        command_from_batch,   // Error came from batch buffer
  input  wire        condition_wait,       // Waiting on condition code
  output reg         report_request,       // Head report write pulse
  output reg  [31:0] report_data,          // Head pointer to report
  output reg         memory_flush_request, // Chipset buffer flush pulse
  output reg         snoop_flush_request,  // Cacheable write flush pulse
  input  wire        snoop_flush_done,     // Cacheable flush finished
  input  wire [31:0] engine_done           // Per-engine done levels
);

  reg  [31:0] ring_start_address;
  reg  [31:0] ring_length_control;
  reg  [17:0] tail_qword;
  reg  [18:0] head_dword;
  reg  [10:0] wrap_count;
  reg         condition_flag;
  reg  [31:0] pending_head_pointer;
  reg  [31:0] parser_error_location;
  reg  [31:0] parser_error_header;
  reg  [31:0] snoop_flush_sync;
  reg  [31:0] unit_done_status;
  reg         fetch_busy;
  reg  [19:0] next_head;
  reg  [10:0] next_wrap;
  reg  [19:0] jump_head;
  reg  [31:0] jump_offset;
  reg         report_hit;
  reg  [31:0] read_mux;

  // Control fields and ring geometry
  wire        ring_enable = ring_length_control[`CTRL_ENABLE_BIT];
  wire        ring_wait   = ring_length_control[`CTRL_WAIT_BIT];
  wire [1:0]  report_mode = ring_length_control[`CTRL_REPORT_MSB:`CTRL_REPORT_LSB];
  wire [8:0]  length_pages = ring_length_control[`CTRL_LENGTH_MSB:`CTRL_LENGTH_LSB];
  wire [19:0] ring_dwords = ({11'h000, length_pages} + 20'h00001) * `PAGE_DWORDS;
  wire [18:0] tail_dword = {tail_qword, 1'b0};
  wire        ring_empty = (head_dword == tail_dword);

  // Register address match
  function hit;
    input [15:0] address;
    input [15:0] offset;
    begin
      hit = (address == offset);
    end
  endfunction

  // Write strobes, one per writable offset
  wire wr_tail    = reg_write && hit(reg_address, `OFS_RING_TAIL);
  wire wr_head    = reg_write && hit(reg_address, `OFS_RING_HEAD);
  wire wr_start   = reg_write && hit(reg_address, `OFS_RING_START_ADDRESS);
  wire wr_control = reg_write && hit(reg_address, `OFS_RING_LENGTH_CTRL);
  wire wr_snoop   = reg_write && hit(reg_address, `OFS_ERROR_LOCATION);
  wire wr_pending = reg_write && hit(reg_address, `OFS_PENDING_HEAD_PTR);

  // Fetch answer and pre-emption jump events
  wire fetch_done = fetch_busy && fetch_data_valid;
  wire take_jump  = command_arb_check && pending_head_pointer[0];

  // Next head position with wrap at ring length, and report boundary test
  // Report boundaries are tested on the head value after the advance
  always @*
  begin
    next_head = {1'b0, head_dword} + 20'h00001;
    if (next_head >= ring_dwords)
      next_head = 20'h00000;
    next_wrap = (next_head == 20'h00000) ? wrap_count + 11'h001 : wrap_count;
    // Pending pointer as a dword head offset; bits beyond the 2 MB ring reach drop
    jump_offset = {pending_head_pointer[31:3], 3'h0} - {ring_start_address[31:12], 12'h000};
    jump_head = {1'b0, jump_offset[20:3], 1'b0};
    report_hit = 1'b0;
    case (report_mode)
      `REPORT_EVERY_64K:
        report_hit = per_process_mode ? (next_head[9:0] == 10'h000)
                                      : (next_head[13:0] == 14'h0000);
      `REPORT_EVERY_128K:
        report_hit = (next_head[14:0] == 15'h0000);
      default:
        report_hit = 1'b0;
    endcase
  end

  // Start address, tail and control fields; the ring wait flag shares this
  // process so the control word has a single driver
  always @(posedge clock)
  begin
    if (reset)
    begin
      ring_start_address <= `RESET_ZERO;
      tail_qword <= 18'h00000;
      ring_length_control <= `RESET_ZERO;
    end
    else
    begin
      if (wr_start)
        ring_start_address <= {3'h0, reg_write_data[28:12], 12'h000};
      if (wr_tail)
        tail_qword <= reg_write_data[20:3];
      if (wr_control)
      begin
        ring_length_control[`CTRL_ENABLE_BIT] <= reg_write_data[0];
        ring_length_control[2:1] <= reg_write_data[2:1];
        ring_length_control[10:3] <= 8'h00;
        ring_length_control[20:12] <= reg_write_data[20:12];
        ring_length_control[31:21] <= 11'h000;
      end
      // Hardware set of the wait flag wins over a software write-one clear
      if (command_wait_event)
        ring_length_control[`CTRL_WAIT_BIT] <= 1'b1;
      else if ((wr_control && reg_write_data[`CTRL_WAIT_BIT]) || event_satisfied)
        ring_length_control[`CTRL_WAIT_BIT] <= 1'b0;
    end
  end

  // Head offset and wrap count
  // Software writes win over a jump, and a jump over the fetch advance
  always @(posedge clock)
  begin
    if (reset)
    begin
      head_dword <= 19'h00000;
      wrap_count <= 11'h000;
    end
    else if (wr_start)
    begin
      head_dword <= 19'h00000;
      wrap_count <= 11'h000;
    end
    else if (wr_head)
    begin
      head_dword <= reg_write_data[20:2];
      wrap_count <= reg_write_data[31:21];
    end
    else if (take_jump)
      head_dword <= jump_head[18:0];
    else if (fetch_done)
    begin
      head_dword <= next_head[18:0];
      if (next_head == 20'h00000)
        wrap_count <= wrap_count + 11'h001;
    end
  end

  // Pending head pointer: hardware clears valid once used
  // A software write in the same cycle as an arbitration check wins
  always @(posedge clock)
  begin
    if (reset)
      pending_head_pointer <= `RESET_ZERO;
    else if (wr_pending)
      pending_head_pointer <= {reg_write_data[31:3], 2'b00, reg_write_data[0]};
    else if (take_jump)
      pending_head_pointer[0] <= 1'b0;
  end

  // Ring fetch: global table only, stop when empty, disabled or waiting
  always @(posedge clock)
  begin
    if (reset)
    begin
      fetch_busy <= 1'b0;
      fetch_request <= 1'b0;
      fetch_address <= `RESET_ZERO;
      fetch_global_table <= 1'b1;
      instruction_valid <= 1'b0;
      instruction_data <= `RESET_ZERO;
    end
    else
    begin
      fetch_global_table <= 1'b1;
      // The dword goes to the parser the cycle after memory answers
      instruction_valid <= fetch_done;
      if (fetch_done)
        instruction_data <= fetch_data;
      if (fetch_done)
      begin
        fetch_busy <= 1'b0;
        fetch_request <= 1'b0;
      end
      // A head or start write, or a jump, moves the head this cycle, so no
      // fetch may launch from the stale offset
      else if (!fetch_busy && ring_enable && !ring_wait && !ring_empty
               && !take_jump && !wr_head && !wr_start)
      begin
        fetch_busy <= 1'b1;
        fetch_request <= 1'b1;
        fetch_address <= ring_start_address + {11'h000, head_dword, 2'b00};
      end
    end
  end

  // Automatic head pointer report
  // The report carries the head after the advance, wrap count included
  always @(posedge clock)
  begin
    if (reset)
    begin
      report_request <= 1'b0;
      report_data <= `RESET_ZERO;
    end
    else
    begin
      report_request <= fetch_done && report_hit;
      if (fetch_done && report_hit)
        report_data <= {next_wrap, next_head[18:0], 1'b0, condition_flag};
    end
  end

  // Parser error capture, condition indicator and engine done status
  // Error location changes only on an error; the header follows every instruction
  always @(posedge clock)
  begin
    if (reset)
    begin
      parser_error_location <= `RESET_ZERO;
      parser_error_header <= `RESET_ZERO;
      condition_flag <= 1'b0;
      unit_done_status <= `RESET_UNIT_DONE;
    end
    else
    begin
      condition_flag <= condition_wait;
      if (command_header_valid)
        parser_error_header <= command_header;
      if (command_error)
        parser_error_location <= {28'h0000000, command_from_batch, `RING_ID_RING0};
      unit_done_status <= (engine_done & `UNIT_DONE_IMPL_MASK) | {31'h00000000, ring_enable};
    end
  end

  // Snoop flush: pending value reads back until the flush completes
  // A new non-zero write wins over a flush completing in the same cycle
  always @(posedge clock)
  begin
    if (reset)
    begin
      snoop_flush_sync <= `RESET_ZERO;
      snoop_flush_request <= 1'b0;
    end
    else
    begin
      snoop_flush_request <= wr_snoop && (reg_write_data != 32'h00000000);
      if (wr_snoop && (reg_write_data != 32'h00000000))
        snoop_flush_sync <= reg_write_data;
      else if (snoop_flush_done)
        snoop_flush_sync <= `RESET_ZERO;
    end
  end

  // Read data selection
  always @*
  begin
    read_mux = `RESET_ZERO;
    case (reg_address)
      `OFS_RING_TAIL:          read_mux = {11'h000, tail_qword, 3'h0};
      `OFS_RING_HEAD:          read_mux = {wrap_count, head_dword, 1'b0, condition_flag};
      `OFS_RING_START_ADDRESS: read_mux = ring_start_address;
      `OFS_RING_LENGTH_CTRL:   read_mux = ring_length_control;
      `OFS_MEMORY_READ_SYNC:   read_mux = `RESET_ZERO;
      // Shared offset: a pending snoop value shows first, else the error location
      `OFS_ERROR_LOCATION:     read_mux = (snoop_flush_sync != 32'h00000000) ? snoop_flush_sync
                                                                        : parser_error_location;
      `OFS_ERROR_HEADER:       read_mux = parser_error_header;
      `OFS_UNIT_DONE_STATUS:   read_mux = unit_done_status;
      `OFS_PENDING_HEAD_PTR:   read_mux = pending_head_pointer;
      default:                 read_mux = `RESET_ZERO;
    endcase
  end

  // Registered read answer and memory read sync flush
  // Read data holds until the next read strobe
  always @(posedge clock)
  begin
    if (reset)
    begin
      reg_read_data <= `RESET_ZERO;
      reg_read_valid <= 1'b0;
      memory_flush_request <= 1'b0;
    end
    else
    begin
      reg_read_valid <= reg_read;
      memory_flush_request <= reg_read && hit(reg_address, `OFS_MEMORY_READ_SYNC);
      if (reg_read)
        reg_read_data <= read_mux;
    end
  end

endmodule

// [include/ring_command_buffer_consts.vh]
// Constants for the ring command buffer register bank.
// Assumes a 16-bit byte offset on the register port and 32-bit data.
`ifndef RING_COMMAND_BUFFER_CONSTS_VH
`define RING_COMMAND_BUFFER_CONSTS_VH

// Register byte offsets
`define OFS_RING_TAIL          16'h2030
`define OFS_RING_HEAD          16'h2034
`define OFS_RING_START_ADDRESS 16'h2038
`define OFS_RING_LENGTH_CTRL   16'h203c
`define OFS_MEMORY_READ_SYNC   16'h2060
`define OFS_ERROR_LOCATION     16'h2064
`define OFS_ERROR_HEADER       16'h2068
`define OFS_UNIT_DONE_STATUS   16'h206c
`define OFS_PENDING_HEAD_PTR   16'h2134

// Control field positions
`define CTRL_ENABLE_BIT        0
`define CTRL_REPORT_LSB        1
`define CTRL_REPORT_MSB        2
`define CTRL_WAIT_BIT          11
`define CTRL_LENGTH_LSB        12
`define CTRL_LENGTH_MSB        20

// Automatic report encodings
`define REPORT_DISABLED        2'h0
`define REPORT_EVERY_64K       2'h1
`define REPORT_RESERVED        2'h2
`define REPORT_EVERY_128K      2'h3

// Error location fields
`define ERRLOC_BATCH_BIT       3
`define RING_ID_RING0          3'h0

// Reset values
`define RESET_ZERO             32'h00000000
`define RESET_UNIT_DONE        32'h0ffe7ffe
`define UNIT_DONE_IMPL_MASK    32'h0ffe7ffe

// Dwords per 4 KB page
`define PAGE_DWORDS            20'h00400

`endif

// [dv/ring_command_buffer_asserts.sv]
// Concurrent checks on the ring command buffer register bank ports.
// Bound to the top module; sees only its ports, single clock domain.
module ring_command_buffer_asserts (
  input logic        clock,                // Clock
  input logic        reset,                // Reset
  input logic        reg_write,            // Write strobe
  input logic        reg_read,             // Read strobe
  input logic [15:0] reg_address,          // Offset
  input logic [31:0] reg_write_data,       // Write data
  input logic [31:0] reg_read_data,        // Read data
  input logic        fetch_request,        // Fetch request
  input logic [31:0] fetch_address,        // Fetch address
  input logic        fetch_global_table,   // Table select
  input logic        fetch_data_valid,     // Fetch answer
  input logic [31:0] fetch_data,           // Fetch dword
  input logic        instruction_valid,    // Parser dword valid
  input logic [31:0] instruction_data,     // Parser dword
  input logic        command_header_valid, // Header valid
  input logic [31:0] command_header,       // Header
  input logic        memory_flush_request, // Chipset flush
  input logic        snoop_flush_request   // Snoop flush
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  a_global_table: assert property (fetch_global_table)
    else $error("fetch not through global table");
  a_sync_zero: assert property (reg_read && reg_address == 16'h2060 |=>
    reg_read_data == 32'h0 && memory_flush_request) else $error("sync read not zero or no flush");
  a_start_aligned: assert property (reg_read && reg_address == 16'h2038 |=>
    reg_read_data[11:0] == 12'h0 && reg_read_data[31:29] == 3'h0) else $error("start address not aligned");
  a_fetch_hold: assert property (fetch_request && !fetch_data_valid |=>
    fetch_request && $stable(fetch_address)) else $error("fetch request not held");
  a_instr_pass: assert property (fetch_request && fetch_data_valid |=> instruction_valid &&
    !fetch_request && instruction_data == $past(fetch_data)) else $error("fetched dword not passed on");
  a_no_stray: assert property (!(fetch_request && fetch_data_valid) |=> !instruction_valid)
    else $error("dword without fetch");
  a_snoop_pulse: assert property (reg_write && reg_address == 16'h2064 && reg_write_data != 32'h0
    |=> snoop_flush_request) else $error("no snoop flush");
  a_header_load: assert property (command_header_valid ##1 !command_header_valid ##1
    (!command_header_valid && reg_read && reg_address == 16'h2068)
    |=> reg_read_data == $past(command_header, 3)) else $error("header not captured");

  c_fetch: cover property (fetch_request && fetch_data_valid);
  c_snoop: cover property (snoop_flush_request);
  c_flush: cover property (memory_flush_request);
endmodule

bind ring_command_buffer_regs ring_command_buffer_asserts u_ring_command_buffer_asserts (.*);

// [dv/ring_memory_model.sv]
// Graphics memory model answering ring fetches one dword at a time.
// Assumes one outstanding fetch; answers alternate prompt and slow.
module ring_memory_model (
  input  logic        clock,              // Core clock
  input  logic        reset,              // Sync reset
  input  logic        fetch_request,      // Fetch request
  input  logic [31:0] fetch_address,      // Fetch address
  input  logic        fetch_global_table, // Table select
  output logic        fetch_data_valid,   // Answer pulse
  output logic [31:0] fetch_data          // Answer dword
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] delay;
  logic       slow;

  // Idle values at time zero
  initial
  begin
    fetch_data_valid = 1'b0;
    fetch_data = 32'h0;
    delay = 2'h0;
    slow = 1'b0;
  end

  // Answers a held request; the data line churns between answers
  always @(posedge clock)
  begin
    fetch_data_valid <= 1'b0;
    fetch_data <= fetch_data + 32'h9e3779b9;
    if (!reset && fetch_request && !fetch_data_valid && fetch_global_table)
    begin
      if (delay == 2'h0)
      begin
        fetch_data_valid <= 1'b1;
        fetch_data <= ~fetch_address;
        slow <= ~slow;
        delay <= slow ? 2'h0 : 2'h3;
      end
      else
        delay <= delay - 2'h1;
    end
  end
endmodule

// [dv/test_ring_command_buffer_regs.sv]
// Self-checking bench for the ring command buffer register bank.
// Drives the register strobes and parser events; memory model answers fetches.
module test_ring_command_buffer_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, reset = 1, reg_write = 0, reg_read = 0, per_process_mode = 0;
  logic [15:0] reg_address = 16'h0;
  logic [31:0] reg_write_data = 32'h0, engine_done = 32'hffffffff, command_header = 32'h0;
  logic        command_header_valid = 0, command_wait_event = 0, event_satisfied = 0;
  logic        command_arb_check = 0, command_error = 0, command_from_batch = 0;
  logic        condition_wait = 0, snoop_flush_done = 0;
  logic [31:0] reg_read_data, fetch_address, fetch_data, instruction_data, report_data, last_report;
  logic        reg_read_valid, fetch_request, fetch_global_table, fetch_data_valid, instruction_valid;
  logic        report_request, memory_flush_request, snoop_flush_request;
  logic [15:0] ofs [7] = '{16'h2038, 16'h203c, 16'h2060, 16'h2064, 16'h2068, 16'h2134, 16'h2100};
  logic [31:0] ctl [4] = '{32'h3, 32'h7, 32'h5, 32'h1}, rep [4] = '{32'h1, 32'h2, 32'h2, 32'h2};
  int          n_fail = 0, num_checks = 0, n_instr = 0, n_report = 0, i;

  always #20 clock = ~clock;
  ring_command_buffer_regs u_ring_command_buffer_regs (.*);
  ring_memory_model u_ring_memory_model (.*);

  // Counts parser dwords and head reports
  always @(posedge clock)
  begin
    if (instruction_valid === 1'b1)
      n_instr <= n_instr + 1;
    if (report_request === 1'b1)
    begin
      n_report <= n_report + 1;
      last_report <= report_data;
    end
  end

  task check(input logic [31:0] seen, input logic [31:0] want, input string what);
    num_checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("[FAIL] %0t %s: saw %h want %h", $time, what, seen, want);
    end
  endtask

  task end_of_test;
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_address <= a;
    reg_write_data <= d;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task rd(input logic [15:0] a, input logic [31:0] want);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_address <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check({31'h0, reg_read_valid}, 32'h1, "read valid");
    check(reg_read_data, want, "read data");
  endtask

  // Bounded wait for a number of parser dwords
  task wait_instr(input int n);
    for (int k = 0; k < 400 && n_instr < n; k++)
      @(posedge clock);
    if (n_instr < n)
    begin
      n_fail++;
      end_of_test;
    end
    repeat (4) @(posedge clock);
  endtask

  initial
  begin
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    foreach (ofs[j]) rd(ofs[j], 32'h0);
    rd(16'h206c, 32'h0ffe7ffe);
    $display("Reset values done");
    wr(16'h2034, 32'h00200010);
    rd(16'h2034, 32'h00200010);
    wr(16'h2038, 32'hffffffff);
    rd(16'h2038, 32'h1ffff000);
    rd(16'h2034, 32'h0);
    wr(16'h2038, 32'h00100000);
    wr(16'h203c, 32'hffffffff);
    rd(16'h203c, 32'h001ff007);
    wr(16'h203c, 32'h0);
    @(posedge clock) command_wait_event <= 1'b1;
    @(posedge clock) command_wait_event <= 1'b0;
    rd(16'h203c, 32'h00000800);
    wr(16'h203c, 32'h0);
    rd(16'h203c, 32'h00000800);
    wr(16'h203c, 32'h00000800);
    rd(16'h203c, 32'h0);
    @(posedge clock) command_wait_event <= 1'b1;
    @(posedge clock) command_wait_event <= 1'b0;
    @(posedge clock) event_satisfied <= 1'b1;
    @(posedge clock) event_satisfied <= 1'b0;
    rd(16'h203c, 32'h0);
    @(posedge clock) condition_wait <= 1'b1;
    rd(16'h2034, 32'h00000001);
    @(posedge clock) condition_wait <= 1'b0;
    @(posedge clock) engine_done <= 32'h0;
    wr(16'h206c, 32'hffffffff);
    rd(16'h206c, 32'h0);
    $display("Control fields done");
    for (i = 0; i < 4; i++)
    begin
      @(posedge clock) per_process_mode <= (i == 0);
      wr(16'h2034, 32'h00000ff8);
      wr(16'h2030, 32'h00000008);
      wr(16'h203c, ctl[i]);
      wait_instr(4 * (i + 1));
      rd(16'h2034, 32'h00200008);
      check(instruction_data, ~32'h00100004, "last dword");
      check(n_report, rep[i], "report count");
      wr(16'h203c, 32'h0);
    end
    check(last_report, 32'h00200000, "report data");
    $display("Ring fetch done");
    wr(16'h2038, 32'h00100000);
    wr(16'h2134, 32'h00100021);
    @(posedge clock) command_arb_check <= 1'b1;
    @(posedge clock) command_arb_check <= 1'b0;
    rd(16'h2134, 32'h00100020);
    rd(16'h2034, 32'h00000020);
    @(posedge clock) command_arb_check <= 1'b1;
    @(posedge clock) command_arb_check <= 1'b0;
    rd(16'h2034, 32'h00000020);
    $display("Pending pointer done");
    rd(16'h2060, 32'h0);
    @(posedge clock)
    begin
      command_error <= 1'b1;
      command_from_batch <= 1'b1;
    end
    @(posedge clock) command_error <= 1'b0;
    wr(16'h2064, 32'h0);
    rd(16'h2064, 32'h00000008);
    wr(16'h2064, 32'h00000005);
    rd(16'h2064, 32'h00000005);
    @(posedge clock) snoop_flush_done <= 1'b1;
    @(posedge clock) snoop_flush_done <= 1'b0;
    rd(16'h2064, 32'h00000008);
    @(posedge clock)
    begin
      command_error <= 1'b1;
      command_from_batch <= 1'b0;
    end
    @(posedge clock) command_error <= 1'b0;
    rd(16'h2064, 32'h0);
    @(posedge clock)
    begin
      command_header_valid <= 1'b1;
      command_header <= 32'h12345678;
    end
    @(posedge clock) command_header_valid <= 1'b0;
    rd(16'h2068, 32'h12345678);
    $display("Debug registers done");
    end_of_test;
  end
endmodule
